// [rtl/byte_alu_datapath.v]
// Byte ALU datapath: add, AND, bit set/clear and bit-test-skip
`timescale 1ns/1ns
`include "byte_alu_regs.vh"
module byte_alu_datapath #(
   parameter DATA_W = 8,
   parameter ADDR_W = 7
) (
   // Clock and reset
   input wire mclk,
   input wire sys_rst,
   // Decoded instruction from the sequencer
   input wire instr_valid,
   input wire [2:0] opcode,
   input wire [DATA_W-1:0] literal,
   input wire [ADDR_W-1:0] reg_addr,
   input wire dest_sel,
   input wire [2:0] bit_index,
   // File register read port, combinational data at reg_addr
   input wire [DATA_W-1:0] file_rdata,
   // File register write port
   output reg file_we_ff,
   output reg [ADDR_W-1:0] file_waddr_ff,
   output reg [DATA_W-1:0] file_wdata_ff,
   // Accumulator and status
   output reg [DATA_W-1:0] acc_ff,
   output reg carry_ff,
   output reg nibble_overflow_flag_ff,
   output reg zero_ff,
   // Skip request: sequencer runs a no-operation instead of the next word
   output reg skip_next_ff
);

   // Next-state value of every register
   reg [DATA_W-1:0] nxt_acc;
   reg nxt_carry;
   reg nxt_nibble;
   reg nxt_zero;
   reg nxt_we;
   reg [ADDR_W-1:0] nxt_waddr;
   reg [DATA_W-1:0] nxt_wdata;
   reg nxt_skip;

   // Decoded instruction class, all low in a dropped slot except to_register, which follows dest_sel
   reg is_add;
   reg is_and;
   reg is_literal;
   reg is_bit_clear;
   reg is_bit_set;
   reg is_bit_test;
   reg to_register;

   // Datapath intermediates
   reg [DATA_W-1:0] operand;
   reg [DATA_W:0] sum_full;
   reg [4:0] sum_low;
   reg [DATA_W-1:0] and_result;
   reg [DATA_W-1:0] alu_result;
   reg alu_zero;
   reg tested_bit;
   wire [DATA_W-1:0] bit_mask;
   wire exec;
   genvar gi;

   // An instruction in the slot after a taken skip is dropped
   assign exec = instr_valid & ~skip_next_ff; // RULE_09

   // Instruction class decode
   always @* begin
      is_add = 1'b0;
      is_and = 1'b0;
      is_literal = 1'b0;
      is_bit_clear = 1'b0;
      is_bit_set = 1'b0;
      is_bit_test = 1'b0;
      if (exec) begin
         case (opcode)
            `OP_ADD_LITERAL: begin
               is_add = 1'b1; // RULE_01
               is_literal = 1'b1;
            end
            `OP_ADD_REGISTER: begin
               is_add = 1'b1; // RULE_02
            end
            `OP_AND_LITERAL: begin
               is_and = 1'b1; // RULE_04
               is_literal = 1'b1;
            end
            `OP_AND_REGISTER: begin
               is_and = 1'b1; // RULE_05
            end
            `OP_BIT_CLEAR: begin
               is_bit_clear = 1'b1; // RULE_06
            end
            `OP_BIT_SET: begin
               is_bit_set = 1'b1; // RULE_07
            end
            `OP_BIT_TEST_SKIP: begin
               is_bit_test = 1'b1; // RULE_08
            end
            default: begin
               is_add = 1'b0; // No-op changes nothing
            end
         endcase
      end
      // Literal forms always write the accumulator
      to_register = ~is_literal & (dest_sel != `DEST_ACCUMULATOR); // RULE_03
   end

   // Second operand: literal or the addressed file register
   always @* begin
      if (opcode == `OP_ADD_LITERAL || opcode == `OP_AND_LITERAL) begin
         operand = literal;
      end else begin
         operand = file_rdata;
      end
   end

   // One-hot mask of the indexed bit, one decoder cell per bit
   generate
      for (gi = 0; gi < DATA_W; gi = gi + 1) begin : g_mask
         assign bit_mask[gi] = (bit_index == gi); // RULE_06 RULE_07
      end
   endgenerate

   // Adder, AND unit and bit tester
   always @* begin
      sum_full = {1'b0, acc_ff} + {1'b0, operand}; // RULE_01 RULE_02
      sum_low = {1'b0, acc_ff[3:0]} + {1'b0, operand[3:0]}; // RULE_10
      and_result = acc_ff & operand; // RULE_04 RULE_05
      if (is_add) begin
         alu_result = sum_full[DATA_W-1:0];
      end else begin
         alu_result = and_result;
      end
      alu_zero = (alu_result == {DATA_W{1'b0}}); // RULE_10
      // Bit under test, picked through the mask
      tested_bit = |(file_rdata & bit_mask); // RULE_08
   end

   // Accumulator next value
   always @* begin
      nxt_acc = acc_ff;
      if ((is_add | is_and) & ~to_register) begin
         nxt_acc = alu_result; // RULE_01 RULE_03 RULE_04
      end
   end

   // Status flags; bit operations and no-op leave them alone
   always @* begin
      nxt_carry = carry_ff;
      nxt_nibble = nibble_overflow_flag_ff;
      nxt_zero = zero_ff;
      if (is_add) begin
         nxt_carry = sum_full[DATA_W]; // RULE_10
         nxt_nibble = sum_low[4]; // RULE_10
      end
      if (is_add | is_and) begin
         nxt_zero = alu_zero; // RULE_04 RULE_05 RULE_10
      end
   end

   // File register write port
   always @* begin
      nxt_we = 1'b0;
      nxt_wdata = file_wdata_ff;
      nxt_waddr = reg_addr;
      if ((is_add | is_and) & to_register) begin
         nxt_we = 1'b1; // RULE_03 RULE_05
         nxt_wdata = alu_result;
      end else if (is_bit_clear) begin
         nxt_we = 1'b1;
         nxt_wdata = file_rdata & ~bit_mask; // RULE_06
      end else if (is_bit_set) begin
         nxt_we = 1'b1;
         nxt_wdata = file_rdata | bit_mask; // RULE_07
      end
   end

   // Skip request holds until the next slot consumes it
   always @* begin
      nxt_skip = skip_next_ff;
      if (instr_valid) begin
         nxt_skip = is_bit_test & ~tested_bit; // RULE_08 RULE_09
      end
   end

   // Accumulator register
   always @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         acc_ff <= `ACC_RESET;
      end else begin
         acc_ff <= nxt_acc;
      end
   end

   // Status flag registers
   always @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         carry_ff <= `FLAG_RESET;
         nibble_overflow_flag_ff <= `FLAG_RESET;
         zero_ff <= `FLAG_RESET;
      end else begin
         carry_ff <= nxt_carry;
         nibble_overflow_flag_ff <= nxt_nibble;
         zero_ff <= nxt_zero;
      end
   end

   // Write port registers, the strobe lasts one cycle
   always @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         file_we_ff <= 1'b0;
         file_waddr_ff <= {ADDR_W{1'b0}};
         file_wdata_ff <= {DATA_W{1'b0}};
      end else begin
         file_we_ff <= nxt_we;
         file_waddr_ff <= nxt_waddr;
         file_wdata_ff <= nxt_wdata;
      end
   end

   // Skip request register
   always @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         skip_next_ff <= 1'b0;
      end else begin
         skip_next_ff <= nxt_skip; // RULE_09
      end
   end

endmodule

// [rtl/byte_alu_regs.vh]
// Constants for the byte ALU and bit-operation datapath
// Overview of operation
// [RULE_01] Add literal to accumulator, update arithmetic flags
// [RULE_02] Add accumulator and file register, update flags
// [RULE_03] Destination bit 0 accumulator, 1 file register
// [RULE_04] AND literal into accumulator, zero flag only
// [RULE_05] AND register to destination, zero flag only
// [RULE_06] Clear indexed bit in register, no flags
// [RULE_07] Set indexed bit in register, no flags
// [RULE_08] Tested bit one: next instruction runs normally
// [RULE_09] Tested bit zero: next becomes no-op, two cycles
// [RULE_10] Carry bit 7, nibble carry bit 3, zero
`ifndef BYTE_ALU_REGS_VH
`define BYTE_ALU_REGS_VH
`define OP_NO_OPERATION 3'h0
`define OP_ADD_LITERAL 3'h1
`define OP_ADD_REGISTER 3'h2
`define OP_AND_LITERAL 3'h3
`define OP_AND_REGISTER 3'h4
`define OP_BIT_CLEAR 3'h5
`define OP_BIT_SET 3'h6
`define OP_BIT_TEST_SKIP 3'h7
`define DEST_ACCUMULATOR 1'h0
`define ACC_RESET 8'h00
`define FLAG_RESET 1'h0
`endif

// [verification/byte_alu_datapath_properties.sv]
// Port checker for the byte ALU datapath
`timescale 1ns/1ns
module byte_alu_datapath_properties(input wire mclk,sys_rst,instr_valid,dest_sel,file_we_ff,
 carry_ff,nibble_overflow_flag_ff,zero_ff,skip_next_ff,input wire [2:0] opcode,bit_index,
 input wire [7:0] literal,file_rdata,file_wdata_ff,acc_ff,input wire [6:0] reg_addr,file_waddr_ff);
   default clocking @(posedge mclk); endclocking
   default disable iff (sys_rst);
   wire go = instr_valid & !skip_next_ff;
   add_lit_a: assert property (go && opcode==1 |=> {carry_ff,acc_ff}==
      $past(acc_ff+literal+9'h0)) else $error("add literal wrong");
   add_reg_a: assert property (go && opcode==2 && dest_sel |=> file_we_ff &&
      file_wdata_ff==$past((acc_ff+file_rdata)&9'h0ff) && $stable(acc_ff))
      else $error("add reg wrong");
   nibble_carry_a: assert property (go && opcode==1 |=> nibble_overflow_flag_ff==
      ($past({1'b0,acc_ff[3:0]}+literal[3:0])>5'hf)) else $error("nibble carry wrong");
   and_lit_a: assert property (go && opcode==3 |=> acc_ff==$past(acc_ff&literal) &&
      zero_ff==(acc_ff==0) && $stable(carry_ff)) else $error("and literal wrong");
   and_reg_a: assert property (go && opcode==4 && !dest_sel |=> !file_we_ff &&
      acc_ff==$past(acc_ff&file_rdata)) else $error("and reg wrong");
   bit_clear_a: assert property (go && opcode==5 |=> file_we_ff && $stable(zero_ff) &&
      file_wdata_ff==$past(file_rdata&~(8'h1<<bit_index))) else $error("bit clear wrong");
   bit_set_a: assert property (go && opcode==6 |=> $stable(carry_ff) &&
      file_wdata_ff==$past(file_rdata|(8'h1<<bit_index))) else $error("bit set wrong");
   skip_set_a: assert property (go && opcode==7 |=> $stable(acc_ff) &&
      skip_next_ff==!$past(file_rdata[bit_index])) else $error("skip request wrong");
   skip_nop_a: assert property (instr_valid && skip_next_ff |=> !skip_next_ff &&
      !file_we_ff && $stable(acc_ff)) else $error("skipped slot acted");
endmodule
bind byte_alu_datapath byte_alu_datapath_properties byte_alu_datapath_properties_i(.*);

// [verification/file_reg_model.sv]
// Data register file facing the datapath
`timescale 1ns/1ns
module file_reg_model(input wire mclk,we,input wire [6:0] ra,wa,input wire [7:0] wd,
 output wire [7:0] rd);
   reg [7:0] mem [0:127];
   integer i;
   initial for (i = 0; i < 128; i = i + 1) mem[i] = i * 37;
   assign rd = mem[ra];
   always @(posedge mclk) if (we) mem[wa] <= wd;
endmodule

// [verification/byte_alu_datapath_tb.sv]
// Self-checking bench for the byte ALU datapath
`timescale 1ns/1ns
module byte_alu_datapath_tb;
   reg mclk=0,sys_rst=1,instr_valid=0,dest_sel=0,c=0,n=0,z=0,k=0;
   reg [2:0] opcode=0,bit_index=0;
   reg [7:0] literal=0,a=0,f;
   reg [6:0] reg_addr=0;
   reg [31:0] s=25;
   integer n_mismatch=0,n_tests=0,i;
   wire file_we_ff,carry_ff,nibble_overflow_flag_ff,zero_ff,skip_next_ff;
   wire [6:0] file_waddr_ff;
   wire [7:0] file_wdata_ff,acc_ff,file_rdata;
   byte_alu_datapath byte_alu_datapath_i(.*);
   file_reg_model file_reg_model_i(.mclk(mclk),.we(file_we_ff),.ra(reg_addr),
      .wa(file_waddr_ff),.wd(file_wdata_ff),.rd(file_rdata));
   initial forever #2 mclk = ~mclk;
   function [31:0] xs(input [31:0] v); reg [31:0] t; begin
      t = v ^ (v << 13); t = t ^ (t >> 17); xs = t ^ (t << 5); end endfunction
   task chk(input [8:0] got,exp); begin
      n_tests = n_tests + 1;
      if (got !== exp) begin
         n_mismatch = n_mismatch + 1; $display("BAD %0t %h %h",$time,got,exp); end end endtask
   task close_out; begin
      if (n_mismatch == 0 && n_tests > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish; end endtask
   // Issue one slot and predict its effect
   task run(input [2:0] o,input [7:0] l,input [6:0] ad,input d,input [2:0] b);
      reg [8:0] t; reg w; begin
      opcode = o; literal = l; reg_addr = ad; dest_sel = d; bit_index = b; instr_valid = 1;
      f = file_reg_model_i.mem[ad]; t = 0; w = 0;
      if (k) k = 0;
      else begin
         case (o)
            1, 2: begin t = a + (o == 1 ? l : f); c = t[8]; z = t[7:0] == 0; w = o == 2 && d;
               n = a[3:0] + (o == 1 ? l[3:0] : f[3:0]) > 15; end
            3, 4: begin t = a & (o == 3 ? l : f); z = t[7:0] == 0; w = o == 4 && d; end
            5: begin t = f & ~(8'h1 << b); w = 1; end
            6: begin t = f | (8'h1 << b); w = 1; end
            7: k = !f[b];
            default: ;
         endcase
         if (o > 0 && o < 5 && !w) a = t[7:0];
      end
      @(negedge mclk);
      chk({file_we_ff,acc_ff},{w,a});
      chk({carry_ff,nibble_overflow_flag_ff,zero_ff,skip_next_ff},{c,n,z,k});
      if (w) chk(file_wdata_ff,t[7:0]);
      if (w) chk(file_waddr_ff,ad);
   end endtask
   initial begin
      repeat (5) @(negedge mclk);
      sys_rst = 0;
      for (i = 0; i < 8; i = i + 1) run(i,8'hff,7'h7f,1,7);
      for (i = 0; i < 600; i = i + 1) begin
         s = xs(s); run(s[2:0],s[15:8],s[22:16],s[23],s[26:24]); end
      close_out;
   end
endmodule
